// file: mmic_pkg.sv
// Constants, field layouts and carrier types of the interrupt controller
package mmic_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_EOS = 6'h22;
    localparam logic [5:0] IDX_POLL = 6'h24;
    localparam logic [5:0] IDX_PSTS = 6'h26;
    localparam logic [5:0] IDX_MASK = 6'h28;
    localparam logic [5:0] IDX_PRIM = 6'h2A;
    localparam logic [5:0] IDX_INSV = 6'h2C;
    localparam logic [5:0] IDX_REQ = 6'h2E;
    localparam logic [5:0] IDX_STAT = 6'h30;
    localparam logic [5:0] IDX_CTRL0 = 6'h32;
    // Sources in fixed tie order: timer, dma0, dma1, ext 0..3
    localparam int NSRC = 7;
    localparam logic [2:0] SRC_TMR = 3'h0;
    localparam logic [2:0] SRC_DMA0 = 3'h1;
    localparam logic [2:0] SRC_DMA1 = 3'h2;
    localparam logic [2:0] SRC_E0 = 3'h3;
    localparam logic [2:0] SRC_E1 = 3'h4;
    // Fixed interrupt types
    localparam logic [4:0] TY_T0 = 5'h08;
    localparam logic [4:0] TY_T1 = 5'h12;
    localparam logic [4:0] TY_T2 = 5'h13;
    localparam logic [4:0] TY_DMA0 = 5'h0A;
    localparam logic [4:0] TY_DMA1 = 5'h0B;
    localparam logic [4:0] TY_E0 = 5'h0C;
    // Field positions
    localparam int POS_PEND = 15;
    localparam int POS_NONSPEC = 15;
    localparam int POS_HALT = 15;
    // Reset values
    localparam logic [2:0] PRI_LOWEST = 3'h7;
    localparam logic [2:0] THR_RESET = 3'h7;
    // Status line code for interrupt acknowledge, and idle
    localparam logic [2:0] ST_INTA = 3'h0;
    localparam logic [2:0] ST_IDLE = 3'h7;
    // Source control register: {snest, casc, ltm, mask, pri}
    typedef struct packed {
        logic snest;
        logic casc;
        logic ltm;
        logic mask;
        logic [2:0] pri;
    } mmic_ctrl_s;
    // Acknowledge sequencer states
    typedef enum logic [2:0] {
        AK_IDLE, AK_P1, AK_G1, AK_G2, AK_P2
    } mmic_ack_e;
endpackage : mmic_pkg

// file: mmic_top.sv
// Master-mode interrupt controller with classic Wishbone register slave
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
module mmic_top
    import mmic_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Internal sources, one-cycle pulses
    input wire logic [2:0] timer_irq_i,
    input wire logic [1:0] dma_irq_i,
    input wire logic nmi_i,
    input wire logic return_from_interrupt_i,
    // External request inputs, levels
    input wire logic ext_request_zero_i,
    input wire logic ext_request_one_i,
    // Dual-purpose pins: request in, acknowledge (active low) out
    input wire logic req_two_or_ack_zero_pin_i,
    output logic req_two_or_ack_zero_pin_o,
    output logic req_two_or_ack_zero_pin_oe_o,
    input wire logic req_three_or_ack_one_pin_i,
    output logic req_three_or_ack_one_pin_o,
    output logic req_three_or_ack_one_pin_oe_o,
    // Processor side
    output logic cpu_int_o,
    input wire logic cpu_inta_i,
    output logic [4:0] cpu_type_o,
    output logic cpu_ext_vector_o,
    output logic [2:0] bus_status_lines_n_o,
    output logic dma_halt_o
);
    // Source index to fixed type; timers resolved by flags
    function automatic logic [4:0] src_type(input logic [2:0] s,
                                            input logic [2:0] tf);
        if (s == SRC_TMR) begin
            src_type = tf[0] ? TY_T0 : (tf[1] ? TY_T1 : TY_T2);
        end else if (s == SRC_DMA0) begin
            src_type = TY_DMA0;
        end else if (s == SRC_DMA1) begin
            src_type = TY_DMA1;
        end else begin
            src_type = TY_E0 + {2'h0, s - SRC_E0};
        end
    endfunction : src_type

    // Byte-lane merge of a write into a 16-bit view
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (d[15:0] & m);
    endfunction : merge

    mmic_ctrl_s ctrl_reg [NSRC];
    logic [2:0] thr_reg;
    logic [NSRC-1:0] insv_reg;
    logic [1:0] dma_req_reg;
    logic [2:0] tflag_reg;
    logic halt_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    mmic_ack_e ak_state_reg;
    logic ak_line_reg;
    logic [4:0] type_reg;
    logic extv_reg;

    // Bus decode; access committed on the edge that raises ack
    logic acc;
    logic [5:0] idx;
    logic wr;
    logic rd_poll;
    assign acc = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign idx = wb_adr_i[7:2];
    assign wr = acc & wb_we_i & (wb_sel_i[1:0] != 2'h0);
    assign rd_poll = acc & ~wb_we_i & (idx == IDX_POLL);

    // Live request vector; external lines are not latched
    logic [NSRC-1:0] req;
    always_comb begin
        req[SRC_TMR] = |tflag_reg;
        req[SRC_DMA0] = dma_req_reg[0];
        req[SRC_DMA1] = dma_req_reg[1];
        req[3] = ext_request_zero_i;
        req[4] = ext_request_one_i;
        req[5] = ~ctrl_reg[SRC_E0].casc & req_two_or_ack_zero_pin_i;
        req[6] = ~ctrl_reg[SRC_E1].casc & req_three_or_ack_one_pin_i;
    end

    // Arbitration: in-service levels act as the priority mask
    logic [NSRC-1:0] elig;
    logic pend;
    logic [2:0] win;
    logic [2:0] best;
    logic [2:0] top_is;
    logic [2:0] top_pri;
    logic any_is;
    always_comb begin
        elig = '0;
        pend = 1'b0;
        win = SRC_TMR;
        best = PRI_LOWEST;
        top_is = SRC_TMR;
        top_pri = PRI_LOWEST;
        any_is = 1'b0;
        for (int s = 0; s < NSRC; s++) begin
            elig[s] = req[s] & ~ctrl_reg[s].mask
                & (ctrl_reg[s].pri <= thr_reg);
            for (int t = 0; t < NSRC; t++) begin
                if (insv_reg[t] && t != s
                    && ctrl_reg[s].pri >= ctrl_reg[t].pri) begin
                    elig[s] = 1'b0;
                end
            end
            if (insv_reg[s] && !ctrl_reg[s].snest) begin
                elig[s] = 1'b0;
            end
        end
        // Descending scan with <= leaves the lowest index on ties
        for (int s = NSRC - 1; s >= 0; s--) begin
            if (elig[s] && (!pend || ctrl_reg[s].pri <= best)) begin
                pend = 1'b1;
                best = ctrl_reg[s].pri;
                win = 3'(s);
            end
            if (insv_reg[s] && (!any_is || ctrl_reg[s].pri <= top_pri)) begin
                any_is = 1'b1;
                top_pri = ctrl_reg[s].pri;
                top_is = 3'(s);
            end
        end
    end

    logic [4:0] win_type;
    logic [15:0] poll_word;
    assign win_type = src_type(win, tflag_reg);
    assign poll_word = pend ? {1'b1, 10'h000, win_type} : 16'h0000;

    // Acknowledge from the CPU or a poll read
    logic ak_busy;
    logic take;
    logic ack_ev;
    assign ak_busy = (ak_state_reg != AK_IDLE);
    assign cpu_int_o = pend & ~ak_busy;
    assign take = cpu_inta_i & cpu_int_o;
    assign ack_ev = take | (rd_poll & pend);

    // End-of-service decode; specific form names a type
    logic [NSRC-1:0] eos_clr;
    always_comb begin
        eos_clr = '0;
        if (wr && idx == IDX_EOS) begin
            if (wb_dat_i[POS_NONSPEC]) begin
                eos_clr[top_is] = any_is;
            end else begin
                for (int s = 0; s < NSRC; s++) begin
                    if (s == SRC_TMR) begin
                        eos_clr[s] = (wb_dat_i[4:0] == TY_T0)
                            | (wb_dat_i[4:0] == TY_T1)
                            | (wb_dat_i[4:0] == TY_T2);
                    end else begin
                        eos_clr[s] = (wb_dat_i[4:0] == src_type(3'(s), 3'h0));
                    end
                end
            end
        end
    end

    // Source control registers; mask bit shared with mask register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int s = 0; s < NSRC; s++) begin
                ctrl_reg[s] <= '{1'b0, 1'b0, 1'b0, 1'b1, PRI_LOWEST};
            end
        end else if (wr) begin
            for (int s = 0; s < NSRC; s++) begin
                if (idx == IDX_CTRL0 + 6'(2 * s)) begin
                    ctrl_reg[s].pri <= 3'(merge({13'h0, ctrl_reg[s].pri},
                        wb_dat_i, wb_sel_i));
                    ctrl_reg[s].mask <= wb_sel_i[0] ? wb_dat_i[3]
                        : ctrl_reg[s].mask;
                    if (s >= SRC_E0) begin
                        ctrl_reg[s].ltm <= wb_sel_i[0] ? wb_dat_i[4]
                            : ctrl_reg[s].ltm;
                    end
                    if (s == SRC_E0 || s == SRC_E1) begin
                        ctrl_reg[s].casc <= wb_sel_i[0] ? wb_dat_i[5]
                            : ctrl_reg[s].casc;
                        ctrl_reg[s].snest <= wb_sel_i[0] ? wb_dat_i[6]
                            : ctrl_reg[s].snest;
                    end
                end else if (idx == IDX_MASK && wb_sel_i[0]) begin
                    ctrl_reg[s].mask <= wb_dat_i[s];
                end
            end
        end
    end

    // Priority threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_reg <= THR_RESET;
        end else if (wr && idx == IDX_PRIM && wb_sel_i[0]) begin
            thr_reg <= wb_dat_i[2:0];
        end
    end

    // In-service: acknowledge set, then end-of-service clear, then write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            insv_reg <= '0;
        end else begin
            for (int s = 0; s < NSRC; s++) begin
                if (ack_ev && win == 3'(s)) begin
                    insv_reg[s] <= 1'b1;
                end else if (eos_clr[s]) begin
                    insv_reg[s] <= 1'b0;
                end else if (wr && idx == IDX_INSV && wb_sel_i[0]) begin
                    insv_reg[s] <= wb_dat_i[s];
                end
            end
        end
    end

    // DMA request latches; a new request wins over a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_req_reg <= '0;
        end else begin
            for (int d = 0; d < 2; d++) begin
                if (dma_irq_i[d]) begin
                    dma_req_reg[d] <= 1'b1;
                end else if (ack_ev && win == SRC_DMA0 + 3'(d)) begin
                    dma_req_reg[d] <= 1'b0;
                end else if (wr && idx == IDX_REQ && wb_sel_i[0]) begin
                    dma_req_reg[d] <= wb_dat_i[1 + d];
                end
            end
        end
    end

    // Timer flags; only the acknowledged timer's flag clears
    logic [2:0] tsel;
    assign tsel = tflag_reg[0] ? 3'h1 : (tflag_reg[1] ? 3'h2 : 3'h4);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tflag_reg <= '0;
        end else begin
            for (int t = 0; t < 3; t++) begin
                if (timer_irq_i[t]) begin
                    tflag_reg[t] <= 1'b1;
                end else if (ack_ev && win == SRC_TMR && tsel[t]) begin
                    tflag_reg[t] <= 1'b0;
                end else if (wr && idx == IDX_STAT && wb_sel_i[0]) begin
                    tflag_reg[t] <= wb_dat_i[t];
                end
            end
        end
    end

    // DMA halt; NMI wins over return and write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_reg <= 1'b0;
        end else if (nmi_i) begin
            halt_reg <= 1'b1;
        end else if (return_from_interrupt_i) begin
            halt_reg <= 1'b0;
        end else if (wr && idx == IDX_STAT && wb_sel_i[1]) begin
            halt_reg <= wb_dat_i[POS_HALT];
        end
    end
    assign dma_halt_o = halt_reg;

    // Readback mux; unmapped indices read zero and still ack
    logic [15:0] rmux;
    always_comb begin
        rmux = 16'h0000;
        if (idx == IDX_POLL || idx == IDX_PSTS) begin
            rmux = poll_word;
        end else if (idx == IDX_MASK) begin
            for (int s = 0; s < NSRC; s++) begin
                rmux[s] = ctrl_reg[s].mask;
            end
        end else if (idx == IDX_PRIM) begin
            rmux[2:0] = thr_reg;
        end else if (idx == IDX_INSV) begin
            rmux[NSRC-1:0] = insv_reg;
        end else if (idx == IDX_REQ) begin
            rmux[NSRC-1:0] = req;
        end else if (idx == IDX_STAT) begin
            rmux = {halt_reg, 12'h000, tflag_reg};
        end else begin
            for (int s = 0; s < NSRC; s++) begin
                if (idx == IDX_CTRL0 + 6'(2 * s)) begin
                    rmux[6:0] = ctrl_reg[s];
                end
            end
        end
    end

    // One wait state: ack and data rise together, ack drops next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= acc;
            if (acc && !wb_we_i) begin
                rdata_reg <= {16'h0000, rmux};
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // Vector hand-off to the CPU, latched at acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            type_reg <= 5'h00;
            extv_reg <= 1'b0;
        end else if (take) begin
            type_reg <= win_type;
            extv_reg <= (win == SRC_E0 || win == SRC_E1)
                && ctrl_reg[win].casc;
        end
    end
    assign cpu_type_o = type_reg;
    assign cpu_ext_vector_o = extv_reg;

    // Two acknowledge pulses with a two-cycle gap; new requests wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ak_state_reg <= AK_IDLE;
            ak_line_reg <= 1'b0;
        end else begin
            case (ak_state_reg)
                AK_IDLE: begin
                    if (take && (win == SRC_E0 || win == SRC_E1)
                        && ctrl_reg[win].casc) begin
                        ak_state_reg <= AK_P1;
                        ak_line_reg <= (win == SRC_E1);
                    end
                end
                AK_P1: begin
                    ak_state_reg <= AK_G1;
                end
                AK_G1: begin
                    ak_state_reg <= AK_G2;
                end
                AK_G2: begin
                    ak_state_reg <= AK_P2;
                end
                default: begin
                    ak_state_reg <= AK_IDLE;
                end
            endcase
        end
    end

    // Pins drive high when cascaded; only the acknowledged line's pin goes low during a pulse
    logic pulse;
    assign pulse = (ak_state_reg == AK_P1) || (ak_state_reg == AK_P2);
    assign req_two_or_ack_zero_pin_oe_o = ctrl_reg[SRC_E0].casc;
    assign req_two_or_ack_zero_pin_o = ~(pulse & ~ak_line_reg);
    assign req_three_or_ack_one_pin_oe_o = ctrl_reg[SRC_E1].casc;
    assign req_three_or_ack_one_pin_o = ~(pulse & ak_line_reg);
    assign bus_status_lines_n_o = ak_busy ? ST_INTA : ST_IDLE;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_two_ack_pulses: assert property ((ak_state_reg == AK_P1) |-> ##3 pulse
        && bus_status_lines_n_o == ST_INTA)
        else $error("second acknowledge pulse missing");
    chk_cascade_blocks: assert property (insv_reg[SRC_E0]
        && !ctrl_reg[SRC_E0].snest |-> !elig[SRC_E0])
        else $error("cascaded line forwarded while in service");
    chk_ack_sets_insv: assert property (ack_ev |=> insv_reg[$past(win)])
        else $error("in-service not set on acknowledge");
    chk_dma_req_clear: assert property (ack_ev && win == SRC_DMA0
        && !dma_irq_i[0] |=> !dma_req_reg[0])
        else $error("dma request kept after acknowledge");
    chk_thr_masks: assert property (pend |-> best <= thr_reg)
        else $error("request above threshold passed");
    chk_psts_quiet: assert property (acc && !wb_we_i && idx == IDX_PSTS
        && !wr |=> $stable(insv_reg))
        else $error("poll status read changed state");
    chk_nmi_halt: assert property (nmi_i |=> halt_reg && dma_halt_o)
        else $error("halt not set by nmi");
    chk_timer_flag: assert property (timer_irq_i[1] |=> tflag_reg[1])
        else $error("timer flag lost");
    chk_bus_ack: assert property (acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
endmodule : mmic_top

// file: mmic_cascade_model.sv
// Behavioural cascaded controller on one request/acknowledge pin pair
module mmic_cascade_model
    import mmic_pkg::*;
#(
    parameter logic [7:0] EXT_TYPE = 8'hA5
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench command and acknowledge pin
    input wire logic raise_i,
    input wire logic ack_n_i,
    input wire logic ack_oe_i,
    // Request line, type bus and pulse count
    output logic req_o,
    output logic [7:0] type_o,
    output logic [1:0] pulses_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Request stays up until the second acknowledge pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_o <= 1'b0;
            pulses_o <= 2'h0;
        end else if (raise_i) begin
            req_o <= 1'b1;
            pulses_o <= 2'h0;
        end else if (ack_oe_i && !ack_n_i) begin
            pulses_o <= pulses_o + 2'h1;
            req_o <= (pulses_o == 2'h0);
        end
    end
    // Type offered only on the second pulse; inverted pattern otherwise
    assign type_o = (ack_oe_i && !ack_n_i && pulses_o == 2'h1) ?
        EXT_TYPE : ~EXT_TYPE;
endmodule : mmic_cascade_model

// file: tb_mmic_top.sv
// Self-checking bench for the master-mode interrupt controller
module tb_mmic_top;
    import mmic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] XT = 8'hA5;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [2:0] tmr = 3'h0;
    logic [1:0] dma = 2'h0;
    logic nmi = 1'b0;
    logic rfi = 1'b0;
    logic inta = 1'b0;
    logic raise = 1'b0;
    logic [31:0] rd;
    logic ack, req0, p2_o, p2_oe, p3_o, p3_oe, cint, extv, halt;
    logic [4:0] ctype;
    logic [2:0] st_n;
    logic [7:0] ptype, xtype;
    logic [1:0] pulses;
    logic [15:0] q;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    int st;
    // A pin in acknowledge mode reads back its own drive
    wire logic p2_w = p2_oe ? p2_o : 1'b0;
    wire logic p3_w = p3_oe ? p3_o : 1'b0;
    // Rows: register index beside its expected reset read
    localparam logic [21:0] ROWS [8] = '{{IDX_PRIM, 16'h0007},
        {IDX_MASK, 16'h007F}, {IDX_CTRL0, 16'h000F},
        {IDX_INSV, 16'h0000}, {IDX_REQ, 16'h0000},
        {IDX_STAT, 16'h0000}, {IDX_PSTS, 16'h0000}, {6'h20, 16'h0000}};
    mmic_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .timer_irq_i(tmr),
        .dma_irq_i(dma), .nmi_i(nmi), .return_from_interrupt_i(rfi),
        .ext_request_zero_i(req0), .ext_request_one_i(1'b0),
        .req_two_or_ack_zero_pin_i(p2_w),
        .req_two_or_ack_zero_pin_o(p2_o),
        .req_two_or_ack_zero_pin_oe_o(p2_oe),
        .req_three_or_ack_one_pin_i(p3_w),
        .req_three_or_ack_one_pin_o(p3_o),
        .req_three_or_ack_one_pin_oe_o(p3_oe), .cpu_int_o(cint),
        .cpu_inta_i(inta), .cpu_type_o(ctype), .cpu_ext_vector_o(extv),
        .bus_status_lines_n_o(st_n), .dma_halt_o(halt));
    mmic_cascade_model #(.EXT_TYPE(XT)) partner (.clk_i(clk_i),
        .rst_i(rst_i), .raise_i(raise), .ack_n_i(p2_w), .ack_oe_i(p2_oe),
        .req_o(req0), .type_o(ptype), .pulses_o(pulses));
    // Free-running 25 MHz clock
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Classic cycle: hold until ack is sampled, then release
    task automatic wb(input logic w, input logic [5:0] i,
        input logic [15:0] d);
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        wd <= {16'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd[15:0];
        cyc <= 1'b0;
        we <= 1'b0;
        if (n >= 20) fails++;
    endtask : wb
    // One-cycle pulse on {tmr, dma, nmi, rfi, inta, raise}
    task automatic pulse(input logic [8:0] v);
        @(posedge clk_i);
        {tmr, dma, nmi, rfi, inta, raise} <= v;
        @(posedge clk_i);
        {tmr, dma, nmi, rfi, inta, raise} <= 9'h000;
    endtask : pulse
    // Acknowledge once the request shows; count status cycles, capture the type
    task automatic take();
        n = 0;
        while (cint !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        pulse(9'h002);
        st = 0;
        repeat (8) begin
            @(posedge clk_i);
            if (st_n === ST_INTA) st++;
            if (p2_w === 1'b0 && pulses === 2'h1) xtype = ptype;
        end
    endtask : take
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, ROWS[i][21:16], 16'h0000);
            chk("reset read", q, ROWS[i][15:0]);
        end
        chk("ack one pins", {14'h0, p3_oe, p3_o}, 16'h0001);
        $display("test reset done");
        wb(1'b1, IDX_MASK, 16'h0000);
        wb(1'b0, IDX_CTRL0, 16'h0000);
        chk("ctrl mask", q, 16'h0007);
        wb(1'b1, 6'h34, 16'h000A);
        wb(1'b0, IDX_MASK, 16'h0000);
        chk("mask view", q, 16'h0002);
        wb(1'b1, 6'h34, 16'h0002);
        wb(1'b1, IDX_REQ, 16'h0006);
        wb(1'b1, IDX_REQ, 16'h0000);
        wb(1'b0, IDX_REQ, 16'h0000);
        chk("req clear", q, 16'h0000);
        pulse(9'h010);
        wb(1'b0, IDX_PSTS, 16'h0000);
        wb(1'b0, IDX_PSTS, 16'h0000);
        chk("poll status", q, 16'h800A);
        wb(1'b0, IDX_REQ, 16'h0000);
        chk("req kept", q, 16'h0002);
        wb(1'b0, IDX_POLL, 16'h0000);
        chk("poll", q, 16'h800A);
        wb(1'b0, IDX_REQ, 16'h0000);
        chk("req acked", q, 16'h0000);
        wb(1'b0, IDX_INSV, 16'h0000);
        chk("insv poll", q, 16'h0002);
        wb(1'b1, IDX_INSV, 16'h0006);
        wb(1'b1, IDX_REQ, 16'h0004);
        wb(1'b1, IDX_EOS, {11'h000, TY_DMA1});
        wb(1'b0, IDX_PSTS, 16'h0000);
        chk("poll low eos", q, 16'h0000);
        wb(1'b0, IDX_INSV, 16'h0000);
        chk("specific eos", q, 16'h0002);
        wb(1'b1, IDX_EOS, 16'h8000);
        wb(1'b0, IDX_POLL, 16'h0000);
        chk("poll top eos", q, 16'h800B);
        wb(1'b1, IDX_EOS, 16'h8000);
        $display("test poll done");
        wb(1'b1, IDX_PRIM, 16'h0001);
        pulse(9'h010);
        wb(1'b0, IDX_PSTS, 16'h0000);
        chk("threshold", q, 16'h0000);
        wb(1'b1, IDX_PRIM, 16'h0007);
        take();
        chk("int type", {11'h000, ctype}, {11'h000, TY_DMA0});
        wb(1'b1, IDX_EOS, 16'h8000);
        wb(1'b1, 6'h38, 16'h0041);
        pulse(9'h001);
        wb(1'b1, IDX_INSV, 16'h0008);
        take();
        chk("internal", {extv, 10'h000, ctype}, {11'h000, TY_E0});
        wb(1'b1, IDX_EOS, 16'h8000);
        $display("test internal done");
        wb(1'b1, 6'h38, 16'h0021);
        take();
        chk("ack status", st[15:0], 16'h0004);
        chk("ack pulses", {14'h0, pulses}, 16'h0002);
        chk("ext type", {7'h00, extv, xtype}, {8'h01, XT});
        pulse(9'h010);
        wb(1'b0, IDX_PSTS, 16'h0000);
        chk("lower blocked", q, 16'h0000);
        pulse(9'h001);
        repeat (4) @(posedge clk_i);
        chk("same line", {15'h0, cint}, 16'h0000);
        wb(1'b1, 6'h38, 16'h0061);
        take();
        chk("nested", {st[7:0], 6'h0, pulses}, 16'h0402);
        wb(1'b1, IDX_EOS, 16'h8000);
        wb(1'b0, IDX_POLL, 16'h0000);
        chk("next source", q, 16'h800A);
        wb(1'b1, IDX_EOS, 16'h8000);
        $display("test cascade done");
        wb(1'b1, IDX_CTRL0, 16'h0000);
        // Status is only read here, never written while timers run
        pulse(9'h1C0);
        wb(1'b0, IDX_STAT, 16'h0000);
        chk("timer flags", q, 16'h0007);
        wb(1'b0, IDX_POLL, 16'h0000);
        chk("timer poll", q, {11'h400, TY_T0});
        pulse(9'h008);
        wb(1'b0, IDX_STAT, 16'h0000);
        chk("flag clear", {halt, q[14:0]}, 16'h8006);
        pulse(9'h004);
        // Halt drops on the edge that samples the return pulse
        @(posedge clk_i);
        chk("halt clear", {15'h0, halt}, 16'h0000);
        wb(1'b1, IDX_EOS, 16'h8000);
        $display("test timer done");
        test_done();
    end
endmodule : tb_mmic_top
